// ===== shared/flash_lock_otp_defs.vh
// Opcodes, field positions, sizes and timing constants of the lock and OTP command block
`ifndef FLASH_LOCK_OTP_DEFS_VH
`define FLASH_LOCK_OTP_DEFS_VH
`define OP_WRITE_ENABLE   8'h06
`define OP_READ_LOCK_A    8'h3C
`define OP_READ_LOCK_B    8'h3D
`define OP_GLOBAL_LOCK    8'h7E
`define OP_GLOBAL_UNLOCK  8'h98
`define OP_OTP_PROGRAM    8'h9B
`define BYTE_LAST_BIT     3'h7
`define HDR_OPCODE        3'h0
`define HDR_ADDR_HI       3'h1
`define HDR_ADDR_LO       3'h3
`define HDR_DONE          3'h4
`define REGION_SHIFT      12
`define OTP_ADDR_MSB      8
`define OTP_SEL_LO        7
`define OTP_BYTE_MSB      6
`define OTP_ERASED        8'hFF
`define OTP_REG_BYTES     10'h080
`define OTP_TOTAL_BYTES   10'h200
`define BUF_FULL_COUNT    9'h100
`define CLK_MHZ           100
`define OTP_PROG_TIME_US  2000
`endif

// ===== rtl/flash_lock_otp.v
// Serial flash lock-bit and OTP security register command block with its byte FIFO
`timescale 1ns/1ps
`include "flash_lock_otp_defs.vh"

// Byte FIFO between the serial receiver and the staging buffer
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire             i_flush,    // Empties the FIFO at frame start
    input  wire             i_valid,    // Fill side offers a word
    output wire             o_ready,    // Fill side may push
    input  wire [WIDTH-1:0] i_data,
    output wire             o_valid,    // Drain side has a word
    input  wire             i_ready,    // Drain side takes the word
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];    // Storage words
    reg [AW:0]      wr_ptr_reg;         // Write pointer with wrap bit
    reg [AW:0]      rd_ptr_reg;         // Read pointer with wrap bit
    wire            full;
    wire            empty;

    assign empty   = (wr_ptr_reg == rd_ptr_reg);
    assign full    = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                     (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign o_ready = ~full;
    assign o_valid = ~empty;
    assign o_data  = mem[rd_ptr_reg[AW-1:0]];

    // Pointer update; storage written on accepted push
    always @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (i_valid && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (i_ready && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // Data storage has no reset
    always @(posedge i_clk) begin
        if (i_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= i_data;
        end
    end
endmodule

// What this block does
// - 3Ch and 3Dh both read lock status
// - Opcode is eight bits, MSB first
// - Address is 24 bits, bit 23 first
// - Status byte out MSB first, bit0 lock
// - Lock 1 refuses program/erase, 0 allows
// - Status byte repeats until chip select rises
// - Region chosen by address above bit 11
// - Global commands abort off byte boundary
// - 7Eh sets every region lock bit
// - 98h clears every region lock bit
// - Global commands act at deselect, clear latch
// - Four 128-byte OTP registers, reg0 factory
// - OTP program uses address bits 8:0 only
// - OTP data bytes accepted while selected
// - Deselect programs buffered bytes, self-timed
// - OTP data staged in shared 256-byte buffer
// - Bits 8:7 pick register, 6:0 byte
// - Programmed MSB byte locks user register
// - Locked target register aborts programming
module flash_lock_otp #(
    parameter REGION_BITS = 7,
    parameter FIFO_DEPTH  = 32,
    parameter FIFO_AW     = 5,
    parameter PROG_CYCLES = `OTP_PROG_TIME_US * `CLK_MHZ
) (
    input  wire                   i_clk,
    input  wire                   i_rst,
    input  wire                   i_cs_n,              // Chip select pin, low active
    input  wire                   i_sck,               // Serial clock pin
    input  wire                   i_si,                // Serial input pin
    output reg                    o_so,                // Serial output pin
    output reg                    o_so_oe,             // High while driving serial output
    input  wire [REGION_BITS-1:0] i_query_region,      // Region asked by program/erase logic
    output reg                    o_query_locked,      // Region refuses program/erase
    output reg                    o_write_enable_latch,
    output wire [2:0]             o_otp_register_locked_flags,
    output wire                   o_busy               // Self-timed program in progress
);
    localparam NREG = 1 << REGION_BITS;
    localparam [3:0] ST_IDLE  = 4'h1;   // Waiting for commands
    localparam [3:0] ST_DRAIN = 4'h2;   // Emptying FIFO into buffer
    localparam [3:0] ST_WAIT  = 4'h4;   // Self-timed program delay
    localparam [3:0] ST_WRITE = 4'h8;   // Commit buffered bytes to OTP

    // Input synchronisers and edge history
    reg [1:0]  cs_sync_reg;
    reg [1:0]  sck_sync_reg;
    reg [1:0]  si_sync_reg;
    reg        cs_n_d_reg;              // Synchronised select, one cycle older
    reg        sck_d_reg;               // Synchronised clock, one cycle older
    wire       cs_n      = cs_sync_reg[1];
    wire       sck       = sck_sync_reg[1];
    wire       si        = si_sync_reg[1];
    wire       sck_rise  = sck & ~sck_d_reg & ~cs_n;
    wire       sck_fall  = ~sck & sck_d_reg & ~cs_n;
    wire       frame_beg = ~cs_n & cs_n_d_reg;
    wire       frame_end = cs_n & ~cs_n_d_reg;

    // Frame decoding state
    reg [7:0]  shift_reg;               // Incoming bits
    reg [2:0]  bit_pos_reg;             // Bits of current byte received
    reg [2:0]  hdr_cnt_reg;             // Header bytes received, saturating
    reg [7:0]  opcode_reg;
    reg [23:0] addr_reg;
    reg        ignore_reg;              // Frame started while busy
    reg        overrun_reg;             // FIFO refused a data byte
    reg [NREG-1:0] lock_reg;            // Per-region lock bits
    reg [3:0]  state_reg;
    reg [8:0]  prog_addr_reg;           // Next OTP byte address
    reg [8:0]  buf_cnt_reg;             // Bytes staged in buffer
    reg [7:0]  buf_idx_reg;             // Read index during commit
    reg [31:0] timer_reg;
    reg [7:0]  stage_buf [0:255];       // Shared internal staging buffer
    reg [7:0]  otp_mem [0:511];         // OTP security registers
    integer    k;

    wire [7:0] new_byte   = {shift_reg[6:0], si};
    wire       byte_done  = sck_rise && (bit_pos_reg == `BYTE_LAST_BIT);
    wire       is_rd_lock = (opcode_reg == `OP_READ_LOCK_A) ||
                            (opcode_reg == `OP_READ_LOCK_B);
    wire       is_otp     = (opcode_reg == `OP_OTP_PROGRAM);
    wire       push       = byte_done && is_otp && !ignore_reg &&
                            (hdr_cnt_reg == `HDR_DONE);
    wire       fifo_ready;
    wire       fifo_valid;
    wire [7:0] fifo_data;
    wire       drain      = fifo_valid && (state_reg != ST_WRITE);
    wire       whole      = (bit_pos_reg == 3'h0);
    wire [1:0] tgt_reg    = prog_addr_reg[`OTP_ADDR_MSB:`OTP_SEL_LO];
    wire [REGION_BITS-1:0] rd_region = addr_reg[`REGION_SHIFT +: REGION_BITS];

    assign o_busy = (state_reg != ST_IDLE);

    // Lock flags follow the most significant byte of each user register
    genvar g;
    generate
        for (g = 1; g < 4; g = g + 1) begin : g_otp_lock
            assign o_otp_register_locked_flags[g-1] =
                otp_mem[g * `OTP_REG_BYTES + `OTP_REG_BYTES - 1] != `OTP_ERASED;
        end
    endgenerate

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_flush (frame_beg && !o_busy),
        .i_valid (push),
        .o_ready (fifo_ready),
        .i_data  (new_byte),
        .o_valid (fifo_valid),
        .i_ready (drain),
        .o_data  (fifo_data)
    );

    // OTP starts erased; register 0 holds factory content outside this block
    initial begin
        for (k = 0; k < 512; k = k + 1) begin
            otp_mem[k] = `OTP_ERASED;
        end
    end

    // Two-flop synchronisers and edge history
    always @(posedge i_clk) begin
        if (i_rst) begin
            cs_sync_reg  <= 2'h3;
            sck_sync_reg <= 2'h0;
            si_sync_reg  <= 2'h0;
            cs_n_d_reg   <= 1'b1;
            sck_d_reg    <= 1'b0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[0], i_cs_n};
            sck_sync_reg <= {sck_sync_reg[0], i_sck};
            si_sync_reg  <= {si_sync_reg[0], i_si};
            cs_n_d_reg   <= cs_n;
            sck_d_reg    <= sck;
        end
    end

    // Serial receive: opcode then 24-bit address, MSB first
    always @(posedge i_clk) begin
        if (i_rst) begin
            shift_reg   <= 8'h00;
            bit_pos_reg <= 3'h0;
            hdr_cnt_reg <= 3'h0;
            opcode_reg  <= 8'h00;
            addr_reg    <= 24'h000000;
            ignore_reg  <= 1'b0;
            overrun_reg <= 1'b0;
        end else if (frame_beg) begin
            bit_pos_reg <= 3'h0;
            hdr_cnt_reg <= 3'h0;
            opcode_reg  <= 8'h00;
            ignore_reg  <= o_busy;
            overrun_reg <= 1'b0;
        end else if (sck_rise) begin
            shift_reg   <= new_byte;
            bit_pos_reg <= bit_pos_reg + 3'h1;
            if (byte_done) begin
                if (hdr_cnt_reg == `HDR_OPCODE) begin
                    opcode_reg <= new_byte;
                end else if (hdr_cnt_reg <= `HDR_ADDR_LO) begin
                    addr_reg <= {addr_reg[15:0], new_byte};
                end
                if (hdr_cnt_reg != `HDR_DONE) begin
                    hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
                end
                if (push && !fifo_ready) begin
                    overrun_reg <= 1'b1;
                end
            end
        end
    end

    // Lock-status reply: shifted on falling clock, byte repeats
    always @(posedge i_clk) begin
        if (i_rst || cs_n) begin
            o_so    <= 1'b0;
            o_so_oe <= 1'b0;
        end else if (sck_fall && is_rd_lock && hdr_cnt_reg == `HDR_DONE) begin
            o_so_oe <= 1'b1;
            o_so    <= (bit_pos_reg == 3'h7) ? lock_reg[rd_region] : 1'b0;
        end
    end

    // Lock bits, write latch and program sequencer
    always @(posedge i_clk) begin
        if (i_rst) begin
            lock_reg             <= {NREG{1'b1}};
            o_write_enable_latch <= 1'b0;
            o_query_locked       <= 1'b1;
            state_reg            <= ST_IDLE;
            prog_addr_reg        <= 9'h000;
            buf_cnt_reg          <= 9'h000;
            buf_idx_reg          <= 8'h00;
            timer_reg            <= 32'h00000000;
        end else begin
            o_query_locked <= lock_reg[i_query_region];
            if (drain) begin
                // Staging overwrites earlier buffer contents
                stage_buf[buf_cnt_reg[7:0]] <= fifo_data;
                if (buf_cnt_reg != `BUF_FULL_COUNT) begin
                    buf_cnt_reg <= buf_cnt_reg + 9'h001;
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (frame_beg) begin
                        buf_cnt_reg <= 9'h000;
                    end
                    if (frame_end && !ignore_reg && whole &&
                        hdr_cnt_reg == `HDR_ADDR_HI) begin
                        if (opcode_reg == `OP_WRITE_ENABLE) begin
                            o_write_enable_latch <= 1'b1;
                        end else if (o_write_enable_latch) begin
                            if (opcode_reg == `OP_GLOBAL_LOCK) begin
                                lock_reg <= {NREG{1'b1}};
                                o_write_enable_latch <= 1'b0;
                            end else if (opcode_reg == `OP_GLOBAL_UNLOCK) begin
                                lock_reg <= {NREG{1'b0}};
                                o_write_enable_latch <= 1'b0;
                            end
                        end
                    end else if (frame_end && !ignore_reg && is_otp) begin
                        if (o_write_enable_latch && whole && !overrun_reg &&
                            hdr_cnt_reg == `HDR_DONE) begin
                            prog_addr_reg <= addr_reg[`OTP_ADDR_MSB:0];
                            state_reg     <= ST_DRAIN;
                        end else begin
                            o_write_enable_latch <= 1'b0;     // Aborted program
                        end
                    end
                end
                ST_DRAIN: begin
                    if (!fifo_valid) begin
                        timer_reg <= PROG_CYCLES;
                        // Factory register and locked user registers refuse
                        if (tgt_reg == 2'h0 || buf_cnt_reg == 9'h000 ||
                            o_otp_register_locked_flags[tgt_reg - 2'h1]) begin
                            o_write_enable_latch <= 1'b0;
                            state_reg            <= ST_IDLE;
                        end else begin
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    timer_reg <= timer_reg - 32'h00000001;
                    if (timer_reg <= 32'h00000001) begin
                        buf_idx_reg <= 8'h00;
                        state_reg   <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    // Programming only clears bits, one byte per cycle
                    otp_mem[prog_addr_reg] <= otp_mem[prog_addr_reg] &
                                              stage_buf[buf_idx_reg];
                    prog_addr_reg <= prog_addr_reg + 9'h001;
                    buf_idx_reg   <= buf_idx_reg + 8'h01;
                    if ({1'b0, buf_idx_reg} == buf_cnt_reg - 9'h001) begin
                        o_write_enable_latch <= 1'b0;
                        state_reg            <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== verif/flash_lock_otp_assertions.sv
// Checker of the lock and OTP command block, watching its ports only
`timescale 1ns/1ps
module flash_lock_otp_checker (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_cs_n,
    input wire logic       o_so_oe,
    input wire logic       o_query_locked,
    input wire logic       o_write_enable_latch,
    input wire logic [2:0] o_otp_register_locked_flags,
    input wire logic       o_busy
);
    // One clock domain, reset masks every check
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    so_idle_a: assert property (i_cs_n [*8] |-> !o_so_oe)
        else $error("serial output driven while deselected");
    so_drive_a: assert property ($rose(o_so_oe) |-> !i_cs_n)
        else $error("serial output enabled outside a frame");
    busy_start_a: assert property ($rose(o_busy) |-> i_cs_n)
        else $error("program started before deselect");
    latch_set_a: assert property ($rose(o_write_enable_latch) |-> i_cs_n)
        else $error("write latch set inside a frame");
    latch_clear_a: assert property ($fell(o_busy) |-> !o_write_enable_latch)
        else $error("write latch still set after program");
    flags_keep_a: assert property (
        !(|($past(o_otp_register_locked_flags) & ~o_otp_register_locked_flags)))
        else $error("OTP lock flag went back to clear");
    flags_time_a: assert property ($changed(o_otp_register_locked_flags)
        |-> $past(o_write_enable_latch) && $past(o_busy))
        else $error("OTP flags changed without enabled program");
    reset_lock_a: assert property ($fell(i_rst) |-> o_query_locked)
        else $error("region not locked after reset");

    // Main scenarios reached
    cover property ($rose(o_so_oe));
    cover property ($fell(o_busy));
    cover property ($fell(o_write_enable_latch) && !o_busy);
endmodule

bind flash_lock_otp flash_lock_otp_checker chk (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .o_so_oe(o_so_oe),
    .o_query_locked(o_query_locked),
    .o_write_enable_latch(o_write_enable_latch),
    .o_otp_register_locked_flags(o_otp_register_locked_flags),
    .o_busy(o_busy)
);

// ===== verif/spi_host_model.sv
// Serial host model that frames commands on the link
`timescale 1ns/1ps
module spi_host_model (
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    input  wire logic i_so
);
    // Idle link: deselected, clock standing low
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b1;
    end
    // Select; odd offset keeps the link out of phase with the system clock
    task automatic sel;
        #43 o_cs_n = 1'b0;
        #40;
    endtask
    // Shift n bits MSB first, reply taken late in the high phase
    task automatic shift(input logic [7:0] d, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int k = 7; k > 7 - n; k--) begin
            o_si = d[k];
            #40 o_sck = 1'b1;
            #39 r[k] = i_so;
            #1 o_sck = 1'b0;
        end
    endtask
    // Deselect; the released data line shows the inverse level
    task automatic desel;
        #40 o_cs_n = 1'b1;
        o_si = ~o_si;
        #200;
    endtask
endmodule

// ===== verif/flash_lock_otp_bench.sv
// Self-checking bench of the lock and OTP command block
`timescale 1ns/1ps
module flash_lock_otp_bench;
    logic       i_clk = 1'b0;          // System clock
    logic       i_rst = 1'b1;          // Synchronous reset
    logic [6:0] i_query_region = 7'h00; // Region asked by program logic
    wire        cs_n, sck, si, so;     // Serial link
    wire        so_oe, locked, latch, busy;
    wire  [2:0] flags;                 // User OTP register locks
    wire        so_seen;               // Output line as the host sees it
    int         errors = 0;
    int         comparisons = 0;

    always #5 i_clk = ~i_clk;

    // Released output line shows the inverse level, so a dropped enable shows up
    assign so_seen = so_oe ? so : ~so;

    spi_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so_seen));
    flash_lock_otp #(.PROG_CYCLES(20)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_query_region(i_query_region),
        .o_query_locked(locked), .o_write_enable_latch(latch),
        .o_otp_register_locked_flags(flags), .o_busy(busy));

    // Verdict and end of run
    task automatic complete_run;
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compare one result
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One frame of whole bytes and an optional partial tail
    task automatic send(input logic [7:0] b[$], input int tail);
        logic [7:0] r;
        host.sel();
        foreach (b[i]) host.shift(b[i], 8, r);
        if (tail > 0) host.shift(8'hA5, tail, r);
        host.desel();
    endtask
    // Read lock frame with two reply bytes
    task automatic read_lock(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e);
        logic [7:0] r1;
        logic [7:0] r2;
        host.sel();
        host.shift(op, 8, r1);
        for (int i = 2; i >= 0; i--) host.shift(a[i*8 +: 8], 8, r1);
        host.shift(8'h00, 8, r1);
        host.shift(8'hFF, 8, r2);
        host.desel();
        chk8(r1, e);
        chk8(r2, e);
    endtask
    // Wait for the self-timed program under a bound
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 5000) begin
            errors++;
            complete_run();
        end
    endtask
    // Pulse reset and check the default locks
    task automatic do_reset;
        @(posedge i_clk);
        #1 i_rst = 1'b1;
        repeat (16) @(posedge i_clk);
        #1 i_rst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        chk8({7'h00, locked}, 8'h01);
        chk8({7'h00, latch}, 8'h00);
    endtask
    // Global unlock, then region query through the side port
    task automatic unlock_and_query;
        send('{8'h06}, 0);
        chk8({7'h00, latch}, 8'h01);
        send('{8'h98}, 0);
        chk8({7'h00, latch}, 8'h00);
        read_lock(8'h3D, 24'h012345, 8'h00);
        @(posedge i_clk);
        #1 i_query_region = 7'h12;
        repeat (3) @(posedge i_clk);
        #1;
        chk8({7'h00, locked}, 8'h00);
    endtask

    // Main sequence
    initial begin
        do_reset();
        read_lock(8'h3C, 24'h000000, 8'h01);
        read_lock(8'h3D, 24'h07F123, 8'h01);
        send('{8'h98}, 0);
        read_lock(8'h3C, 24'h000FFF, 8'h01);
        unlock_and_query();
        do_reset();
        send('{8'h06}, 0);
        send('{8'h98}, 3);
        chk8({7'h00, latch}, 8'h01);
        read_lock(8'h3C, 24'h05A000, 8'h01);
        send('{8'h98}, 0);
        chk8({7'h00, locked}, 8'h00);
        send('{8'h06}, 0);
        send('{8'h7E}, 0);
        read_lock(8'h3C, 24'h07F000, 8'h01);
        chk8({7'h00, locked}, 8'h01);
        send('{8'h9B, 8'h00, 8'h00, 8'hFF, 8'h00}, 0);
        wait_idle();
        chk8({5'h00, flags}, 8'h00);
        send('{8'h06}, 0);
        send('{8'h9B, 8'hAB, 8'hC1, 8'h7E, 8'h5A, 8'h00}, 0);
        chk8({7'h00, busy}, 8'h01);
        wait_idle();
        chk8({5'h00, flags}, 8'h02);
        chk8({7'h00, latch}, 8'h00);
        send('{8'h06}, 0);
        send('{8'h9B, 8'hFF, 8'hFF, 8'hFF, 8'h7F}, 0);
        wait_idle();
        chk8({5'h00, flags}, 8'h06);
        send('{8'h06}, 0);
        send('{8'h9B, 8'h00, 8'h01, 8'h00, 8'h00}, 0);
        chk8({7'h00, busy}, 8'h00);
        chk8({7'h00, latch}, 8'h00);
        wait_idle();
        send('{8'h06}, 0);
        send('{8'h9B, 8'h00, 8'h00, 8'h7F, 8'h00}, 0);
        chk8({7'h00, busy}, 8'h00);
        wait_idle();
        chk8({5'h00, flags}, 8'h06);
        chk8({7'h00, latch}, 8'h00);
        complete_run();
    end
endmodule
